// ### design/lt_pkg.sv
// Package for the 8-bit limit timer: register map, fields, reset values, modes.
// Assumes a single 10 MHz clock and a plain strobe register port.
package lt_pkg;

    localparam logic [3:0] LT_ADDR_COUNT = 4'h0;
    localparam logic [3:0] LT_ADDR_PERIOD = 4'h1;
    localparam logic [3:0] LT_ADDR_CONTROL = 4'h2;
    localparam logic [3:0] LT_ADDR_HLT = 4'h3;
    localparam logic [3:0] LT_ADDR_CLKSEL = 4'h4;
    localparam logic [3:0] LT_ADDR_RSTSEL = 4'h5;
    localparam logic [3:0] LT_ADDR_STATUS = 4'h6;

    // Control fields
    localparam int LT_CTL_ON = 7;
    localparam int LT_CTL_PS_LSB = 4;
    localparam int LT_CTL_POST_LSB = 0;
    // LIMIT_TIMER_FUNCTION fields
    localparam int LT_HLT_PRESCALER_SYNC = 7;
    localparam int LT_HLT_ON_BIT_CLOCK_SYNC = 5;
    localparam int LT_HLT_MODE_LSB = 0;
    // Status fields
    localparam int LT_ST_FLAG = 0;
    localparam int LT_ST_IE = 1;

    localparam logic [7:0] LT_PERIOD_RST = 8'hff;
    localparam logic [7:0] LT_ZERO = 8'h00;
    localparam int LT_CLK_SRC_N = 4;
    localparam int LT_RST_SRC_N = 4;

    localparam logic [1:0] LT_FAM_FREE = 2'b00;
    localparam logic [1:0] LT_FAM_ONESHOT = 2'b01;
    localparam logic [1:0] LT_FAM_MONO = 2'b10;

    typedef enum logic [1:0] {
        LT_IDLE = 2'b00,
        LT_RUN = 2'b01,
        LT_DONE = 2'b10
    } lt_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lt_bus_s;

endpackage

// ### design/lt_timer.sv
// 8-bit period timer with prescaler, postscaler and external reset control.
// Assumes timer_input_clock sources and reset sources are synchronous to clk.
// Summary of operation
// - Prescaler divides by 1 up to 128
// - Postscaler counts matches, 1 up to 16
// - Count increments on each prescaler tick
// - Match flags postscaler, count clears same tick
// - Postscaler match gives one-clk pulse, clears
// - Reset clears count, period loads all ones
// - Scalers clear on count/control writes, reset, external reset
// - Control write keeps count value
// - Gate modes hold count while gate inactive
// - Reset modes clear count on level/edge
// - One-shot clears on bit at match
// - One-shot ignores postscale setting
// - Monostable keeps on bit, restarts on trigger
// - Count and period readable and writable
// - Flag on postscale match, irq when enabled
// - Flag sticky until software clears it
// - Prescaler sync option aligns tick to clk
// - On-sync option consumes one input edge
// - Without on-sync, on bit follows clk
// - Reset source chosen per timer
// - Free-running, one-shot, monostable families
// - Mode upper bits pick family, lower variant
// - Debug mode ignores external triggers
`timescale 1ns/100ps
module lt_timer #(
    parameter int PS_W = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire lt_pkg::lt_bus_s bus,
    output logic [7:0] rdata,
    input wire logic [lt_pkg::LT_CLK_SRC_N-1:0] timer_input_clock,
    input wire logic [lt_pkg::LT_RST_SRC_N-1:0] external_reset_signal,
    input wire logic debug_mode,
    output logic postscaled_pulse,
    output logic match_irq
);
    import lt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_ff, rst_sync_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rst_n = rst_sync_ff;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] count_ff, period_ff, control_ff, hlt_ff;
    logic [7:0] clksel_ff, rstsel_ff;
    logic flag_ff, ie_ff;
    wire logic wr_count = bus.wr && bus.addr == LT_ADDR_COUNT;
    wire logic wr_ctl = bus.wr && bus.addr == LT_ADDR_CONTROL;
    wire logic [1:0] family = hlt_ff[LT_HLT_MODE_LSB+3 +: 2];
    wire logic [2:0] variant = hlt_ff[LT_HLT_MODE_LSB +: 3];
    wire logic on_bit = control_ff[LT_CTL_ON];
    wire logic [PS_W-1:0] ps_sel = control_ff[LT_CTL_PS_LSB +: PS_W];
    wire logic [3:0] post_sel = control_ff[LT_CTL_POST_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////
    // Clock and reset source select
    logic clk_in_ff, clk_in_d_ff, ers_ff, ers_d_ff;
    wire logic clk_sel = timer_input_clock[clksel_ff[1:0]];
    // Triggers frozen in debug; a level change made during debug shows as an edge on resume
    wire logic ers_sel = debug_mode ? ers_ff : external_reset_signal[rstsel_ff[1:0]];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_in_ff <= 1'b0;
            clk_in_d_ff <= 1'b0;
            ers_ff <= 1'b0;
            ers_d_ff <= 1'b0;
        end else begin
            clk_in_ff <= clk_sel;
            clk_in_d_ff <= clk_in_ff;
            ers_ff <= ers_sel;
            ers_d_ff <= ers_ff;
        end
    end
    wire logic in_edge = clk_in_ff && !clk_in_d_ff;
    wire logic ers_rise = ers_ff && !ers_d_ff;
    wire logic ers_fall = !ers_ff && ers_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // Trigger decode per mode
    logic gate_ok, hw_reset, trig;
    always_comb begin
        gate_ok = 1'b1;
        hw_reset = 1'b0;
        trig = 1'b0;
        case (family)
            LT_FAM_FREE: begin
                case (variant)
                    3'd1: gate_ok = ers_ff;
                    3'd2: gate_ok = !ers_ff;
                    3'd3: hw_reset = ers_rise || ers_fall;
                    3'd4: hw_reset = ers_rise;
                    3'd5: hw_reset = ers_fall;
                    3'd6: hw_reset = !ers_ff;
                    3'd7: hw_reset = ers_ff;
                    default: gate_ok = 1'b1;
                endcase
            end
            LT_FAM_ONESHOT, LT_FAM_MONO: begin
                case (variant)
                    3'd0: trig = 1'b1;
                    3'd1, 3'd4, 3'd6: trig = ers_rise;
                    3'd2, 3'd5, 3'd7: trig = ers_fall;
                    default: trig = ers_rise || ers_fall;
                endcase
                if (family == LT_FAM_ONESHOT) begin
                    case (variant)
                        3'd4: hw_reset = ers_rise;
                        3'd5: hw_reset = ers_fall;
                        3'd6: hw_reset = !ers_ff;
                        3'd7: hw_reset = ers_ff;
                        default: hw_reset = 1'b0;
                    endcase
                end
            end
            default: gate_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Run control
    lt_state_e state_ff;
    logic on_sync_ff, on_bit_clock_sync_arm_ff;
    logic tick;
    logic match_tick;
    // On_bit_clock_sync: on bit taken only at an input edge, which is then not counted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_sync_ff <= 1'b0;
            on_bit_clock_sync_arm_ff <= 1'b0;
        end else if (!on_bit) begin
            on_sync_ff <= 1'b0;
            on_bit_clock_sync_arm_ff <= 1'b0;
        end else if (!hlt_ff[LT_HLT_ON_BIT_CLOCK_SYNC]) begin
            on_sync_ff <= 1'b1;
        end else if (in_edge && !on_bit_clock_sync_arm_ff) begin
            on_bit_clock_sync_arm_ff <= 1'b1;
            on_sync_ff <= 1'b1;
        end
    end
    wire logic stop_now = match_tick && family != LT_FAM_FREE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LT_IDLE;
        end else if (!on_sync_ff) begin
            state_ff <= LT_IDLE;
        end else begin
            case (state_ff)
                LT_IDLE: state_ff <= (family == LT_FAM_FREE || trig) ? LT_RUN : LT_IDLE;
                LT_RUN: state_ff <= stop_now ? LT_DONE : LT_RUN;
                LT_DONE: state_ff <= (family == LT_FAM_MONO && trig) ? LT_RUN : LT_DONE;
                default: state_ff <= LT_IDLE;
            endcase
        end
    end
    wire logic running = state_ff == LT_RUN && gate_ok;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    logic [6:0] pre_ff;
    logic tick_ff;
    wire logic scl_clr = wr_count || wr_ctl || hw_reset;
    wire logic [6:0] pre_max = 7'((8'h01 << ps_sel) - 8'h01);
    wire logic pre_out = running && in_edge && pre_ff == pre_max;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 7'h00;
        end else if (scl_clr || !running) begin
            pre_ff <= 7'h00;
        end else if (in_edge) begin
            pre_ff <= pre_out ? 7'h00 : 7'(pre_ff + 7'h01);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= pre_out && !scl_clr;
        end
    end
    // Prescaler_sync adds one clk of latency to align the tick
    assign tick = hlt_ff[LT_HLT_PRESCALER_SYNC] ? tick_ff : (pre_out && !scl_clr);
    assign match_tick = tick && count_ff == period_ff;

    ////////////////////////////////////////////////////////////////////////
    // Count and postscaler
    logic [3:0] post_ff;
    wire logic [3:0] post_lim = (family == LT_FAM_ONESHOT) ? 4'h0 : post_sel;
    wire logic post_hit = match_tick && post_ff == post_lim;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= LT_ZERO;
        end else if (wr_count) begin
            count_ff <= bus.wdata;
        end else if (hw_reset) begin
            count_ff <= LT_ZERO;
        end else if (match_tick) begin
            count_ff <= LT_ZERO;
        end else if (tick) begin
            count_ff <= 8'(count_ff + 8'h01);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            post_ff <= 4'h0;
        end else if (scl_clr || state_ff == LT_IDLE) begin
            post_ff <= 4'h0;
        end else if (post_hit) begin
            post_ff <= 4'h0;
        end else if (match_tick) begin
            post_ff <= 4'(post_ff + 4'h1);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            postscaled_pulse <= 1'b0;
        end else begin
            postscaled_pulse <= post_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_ff <= LT_PERIOD_RST;
        end else if (bus.wr && bus.addr == LT_ADDR_PERIOD) begin
            period_ff <= bus.wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_ff <= LT_ZERO;
        end else if (wr_ctl) begin
            control_ff <= bus.wdata;
        end else if (family == LT_FAM_ONESHOT && stop_now) begin
            control_ff[LT_CTL_ON] <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hlt_ff <= LT_ZERO;
            clksel_ff <= LT_ZERO;
            rstsel_ff <= LT_ZERO;
        end else if (bus.wr) begin
            if (bus.addr == LT_ADDR_HLT) hlt_ff <= bus.wdata;
            if (bus.addr == LT_ADDR_CLKSEL) clksel_ff <= bus.wdata;
            if (bus.addr == LT_ADDR_RSTSEL) rstsel_ff <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match flag and interrupt
    // Set wins over a software clear in the same cycle
    wire logic st_wr = bus.wr && bus.addr == LT_ADDR_STATUS;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
            ie_ff <= 1'b0;
        end else begin
            if (post_hit) begin
                flag_ff <= 1'b1;
            end else if (st_wr && !bus.wdata[LT_ST_FLAG]) begin
                flag_ff <= 1'b0;
            end
            if (st_wr) ie_ff <= bus.wdata[LT_ST_IE];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_irq <= 1'b0;
        end else begin
            match_irq <= flag_ff && ie_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= LT_ZERO;
        end else if (bus.rd) begin
            case (bus.addr)
                LT_ADDR_COUNT: rdata <= count_ff;
                LT_ADDR_PERIOD: rdata <= period_ff;
                LT_ADDR_CONTROL: rdata <= control_ff;
                LT_ADDR_HLT: rdata <= hlt_ff;
                LT_ADDR_CLKSEL: rdata <= clksel_ff;
                LT_ADDR_RSTSEL: rdata <= rstsel_ff;
                LT_ADDR_STATUS: rdata <= {6'h00, ie_ff, flag_ff};
                default: rdata <= LT_ZERO;
            endcase
        end else begin
            rdata <= LT_ZERO;
        end
    end

endmodule // lt_timer

// ### test/lt_timer_asserts.sv
// Checker for lt_timer: read port, pulse width and interrupt timing.
// Assumes one clk domain and the lt_pkg bus struct at the ports.
`timescale 1ns/100ps
module lt_timer_asserts #(
    parameter int PS_W = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire lt_pkg::lt_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic postscaled_pulse,
    input wire logic match_irq
);
    import lt_pkg::*;
    ////////////////////////////////////////////////////////////////
    logic ie_ff;
    logic [7:0] per_ff;
    logic st_wr;
    assign st_wr = bus.wr && bus.addr == LT_ADDR_STATUS;
    // Shadow of enable; irq itself is only seen at the port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ie_ff <= 1'b0;
        end else if (st_wr) begin
            ie_ff <= bus.wdata[LT_ST_IE];
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_ff <= LT_PERIOD_RST;
        end else if (bus.wr && bus.addr == LT_ADDR_PERIOD) begin
            per_ff <= bus.wdata;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_pulse_ie;
        postscaled_pulse && ie_ff ##1 ie_ff;
    endsequence
    property p_pulse_once;
        postscaled_pulse |=> !postscaled_pulse;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("pulse too wide");
    property p_irq_on;
        s_pulse_ie |-> ##[0:1] match_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_irq_off;
        !ie_ff |=> !match_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_flag_sticky;
        match_irq && ie_ff && !$past(st_wr) |=> match_irq;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_period_rd;
        bus.rd && bus.addr == LT_ADDR_PERIOD |=> rdata == per_ff;
    endproperty
    a_period_rd: assert property (p_period_rd) else $error("period read");
    property p_unmapped;
        bus.rd && bus.addr > LT_ADDR_STATUS |=> rdata == LT_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_rd_idle;
        !bus.rd |=> rdata == LT_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_rst_quiet;
        $rose(reset_n) |-> (!postscaled_pulse && !match_irq) [*3];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
endmodule // lt_timer_asserts

// ### test/lt_partner.sv
// Far-side model: divided timer clocks and registered reset lines.
// Assumes clk is the system clock; the bench sets reset levels.
`timescale 1ns/100ps
module lt_partner (
    input wire logic clk,
    input wire logic [3:0] ers_req,
    output logic [3:0] tclk,
    output logic [3:0] ers
);
    logic [3:0] div_ff = 4'h0;
    logic [3:0] ers_ff = 4'h0;
    // Source k runs at clk / 2^(k+1)
    always_ff @(posedge clk) begin
        div_ff <= div_ff + 4'h1;
    end
    always_ff @(posedge clk) begin
        ers_ff <= ers_req;
    end
    assign tclk = div_ff;
    assign ers = ers_ff;
endmodule // lt_partner

// ### test/lt_timer_tb.sv
// Bench for lt_timer: registers, scaler timing, one-shot, monostable, gate.
// Assumes lt_partner clocks; checker bound at the foot.
`timescale 1ns/100ps
module lt_timer_tb;
    import lt_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    lt_bus_s bus = '0;
    logic [7:0] rdata;
    logic [3:0] tclk;
    logic [3:0] ers;
    logic [3:0] ers_req = 4'h0;
    logic debug_mode = 1'b0;
    logic postscaled_pulse;
    logic match_irq;
    logic rd_p = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] per;
    logic [7:0] src_tab[4] = '{8'h00, 8'h01, 8'h00, 8'h02};
    logic [2:0] ps_tab[4] = '{3'h0, 3'h7, 3'h2, 3'h1};
    logic [3:0] po_tab[4] = '{4'h0, 4'h0, 4'hf, 4'h3};
    logic [7:0] gm_tab[4] = '{8'h01, 8'h02, 8'h07, 8'h06};
    logic [3:0] gl = 4'b0110;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 32'h2723;
    int cyc = 0;
    int t0;
    int ex;
    bit got;
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    lt_partner far (.clk(clk), .ers_req(ers_req), .tclk(tclk), .ers(ers));
    lt_timer #(.PS_W(3)) dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .timer_input_clock(tclk), .external_reset_signal(ers), .debug_mode(debug_mode),
        .postscaled_pulse(postscaled_pulse), .match_irq(match_irq));
    ////////////////////////////////////////////////////////////////
    task automatic fail(input string m);
        n_fail++;
        $display("ERROR t=%0t %s", $time, m);
    endtask
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) fail(m);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus <= '0;
    endtask
    task automatic wait_pulse(input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk);
            got = (postscaled_pulse === 1'b1);
        end
    endtask
    // Stop and zero the count first, so a leftover count above the new period cannot wrap
    task automatic measure(input logic [7:0] p, input logic [7:0] ctl, input int e);
        wr(LT_ADDR_CONTROL, 8'h00);
        wr(LT_ADDR_PERIOD, p);
        wr(LT_ADDR_COUNT, LT_ZERO);
        wr(LT_ADDR_CONTROL, ctl);
        wait_pulse(9000);
        t0 = cyc;
        wait_pulse(9000);
        chk(got && cyc - t0 == e, "pulse spacing");
    endtask
    // Read results land one cycle after the strobe
    always @(posedge clk) begin
        if (rd_p) begin
            samples_checked++;
            if (rdata !== exp_q.pop_front()) fail("read data");
        end
        rd_p <= bus.rd;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(LT_ADDR_COUNT, LT_ZERO);
        rd(LT_ADDR_PERIOD, LT_PERIOD_RST);
        rd(4'hf, LT_ZERO);
        for (int i = 0; i < 4; i++) begin
            per = 8'($random(seed));
            wr(LT_ADDR_PERIOD, per);
            rd(LT_ADDR_PERIOD, per);
            wr(LT_ADDR_COUNT, ~per);
            wr(LT_ADDR_CONTROL, per & 8'h7f);
            rd(LT_ADDR_COUNT, ~per);
        end
        $display("register test done");
        wr(LT_ADDR_STATUS, 8'h02);
        for (int k = 0; k < 4; k++) begin
            per = 8'(($random(seed) & 7) | 1);
            wr(LT_ADDR_CLKSEL, src_tab[k]);
            wr(LT_ADDR_HLT, (k == 3) ? 8'h80 : 8'h00);
            ex = (2 << (src_tab[k] + ps_tab[k])) * (per + 1) * (po_tab[k] + 1);
            measure(per, {1'b1, ps_tab[k], po_tab[k]}, ex);
        end
        wr(LT_ADDR_CONTROL, 8'h00);
        rd(LT_ADDR_STATUS, 8'h03);
        chk(match_irq === 1'b1, "irq level");
        wr(LT_ADDR_STATUS, 8'h02);
        rd(LT_ADDR_STATUS, 8'h02);
        chk(match_irq === 1'b0, "irq cleared");
        wr(LT_ADDR_STATUS, 8'h00);
        $display("free-running test done");
        wr(LT_ADDR_COUNT, LT_ZERO);
        wr(LT_ADDR_CLKSEL, 8'h00);
        wr(LT_ADDR_HLT, 8'h08);
        wr(LT_ADDR_PERIOD, 8'h03);
        for (int r = 0; r < 2; r++) begin
            wr(LT_ADDR_CONTROL, 8'h85);
            wait_pulse(40);
            chk(got, "one-shot pulse");
            wait_pulse(100);
            chk(!got, "one-shot stop");
            rd(LT_ADDR_CONTROL, 8'h05);
            rd(LT_ADDR_COUNT, LT_ZERO);
        end
        $display("one-shot test done");
        wr(LT_ADDR_RSTSEL, 8'h02);
        wr(LT_ADDR_HLT, 8'h11);
        wr(LT_ADDR_CONTROL, 8'h80);
        wait_pulse(60);
        chk(!got, "mono waits");
        for (int r = 0; r < 3; r++) begin
            debug_mode <= (r == 2);
            @(posedge clk) ers_req <= 4'h4;
            wait_pulse(60);
            chk(got == (r != 2), "mono trigger");
            rd(LT_ADDR_CONTROL, 8'h80);
            @(posedge clk) ers_req <= 4'h0;
            repeat (20) @(posedge clk);
        end
        debug_mode <= 1'b0;
        wr(LT_ADDR_CONTROL, 8'h00);
        $display("monostable test done");
        for (int m = 0; m < 4; m++) begin
            wr(LT_ADDR_HLT, gm_tab[m]);
            ers_req <= {1'b0, gl[m], 2'b00};
            wr(LT_ADDR_COUNT, LT_ZERO);
            wr(LT_ADDR_CONTROL, 8'h80);
            repeat (40) @(posedge clk);
            rd(LT_ADDR_COUNT, LT_ZERO);
            ers_req <= {1'b0, ~gl[m], 2'b00};
            measure(8'h03, 8'h80, 8);
            wr(LT_ADDR_CONTROL, 8'h00);
        end
        $display("gate and reset test done");
        give_verdict();
    end
    initial begin
        #(100 * 80000);
        fail("watchdog");
        give_verdict();
    end
endmodule // lt_timer_tb
bind lt_timer lt_timer_asserts #(.PS_W(PS_W)) u_chk (.clk(clk), .reset_n(reset_n),
    .bus(bus), .rdata(rdata), .postscaled_pulse(postscaled_pulse), .match_irq(match_irq));
